// File: design/lpr_pkg.sv
// ****************************************************************
// Shared constants of the portrait rotation block.
// ****************************************************************
package lpr_pkg;

  // Width of a display memory byte address.
  localparam int ADDR_W = 17;
  // Width of the register data lane.
  localparam int REG_W  = 8;
  // Width of the register index carried by the bus address.
  localparam int IDX_W  = 6;

  // ****************************************************************
  // Register indices; the byte address is four times the index.
  // ****************************************************************
  localparam logic [IDX_W-1:0] IDX_START_LOW  = 6'h0c;
  localparam logic [IDX_W-1:0] IDX_START_MID  = 6'h0d;
  localparam logic [IDX_W-1:0] IDX_START_TOP  = 6'h0e;
  localparam logic [IDX_W-1:0] IDX_ROT_CTRL   = 6'h1b;
  localparam logic [IDX_W-1:0] IDX_STRIDE     = 6'h1c;
  localparam logic [IDX_W-1:0] IDX_STATUS     = 6'h1d;

  // ****************************************************************
  // Field positions.
  // ****************************************************************
  localparam int CTRL_ENABLE_BIT  = 7;
  localparam int CTRL_SCHEME_BIT  = 6;
  localparam int CTRL_MCLK_BIT    = 2;
  localparam int START_TOP_BIT    = 16;
  localparam int STAT_POW2_BIT    = 0;
  localparam int STAT_BOOST_BIT   = 1;
  localparam int STAT_PORT_BIT    = 2;
  localparam int STAT_ALT_BIT     = 3;
  localparam int STAT_FRAME_BIT   = 4;

  // Writable bits of the rotation control register.
  localparam logic [REG_W-1:0] CTRL_WMASK = 8'hc7;
  // Writable bits of the top start offset register.
  localparam logic [REG_W-1:0] TOP_WMASK  = 8'h01;

  // ****************************************************************
  // Reset values.
  // ****************************************************************
  localparam logic [REG_W-1:0] START_RST  = 8'h00;
  localparam logic [REG_W-1:0] CTRL_RST   = 8'h00;
  localparam logic [REG_W-1:0] STRIDE_RST = 8'h00;

  // ****************************************************************
  // Panel geometry defaults.
  // ****************************************************************
  localparam int PANEL_PIXELS = 320;
  localparam int PANEL_LINES  = 240;

  // Scheme selection.
  typedef enum logic {
    LPR_SCHEME_DEFAULT,
    LPR_SCHEME_ALTERNATE
  } lpr_scheme_type;

endpackage

// File: design/lpr_scan.sv
`timescale 1ns/1ps
// ****************************************************************
// Panel raster counter: pixels along a panel line, then lines.
// ****************************************************************
module lpr_scan #(
  parameter int PIXELS = lpr_pkg::PANEL_PIXELS,
  parameter int LINES  = lpr_pkg::PANEL_LINES
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic pix_en_i,
  output logic      line_first_o,
  output logic      frame_first_o,
  output logic      frame_last_o
);
  import lpr_pkg::*;

  localparam int XW = $clog2(PIXELS);
  localparam int YW = $clog2(LINES);
  localparam logic [XW-1:0] X_LAST = XW'(PIXELS - 1);
  localparam logic [YW-1:0] Y_LAST = YW'(LINES - 1);

  logic [XW-1:0] x_reg;
  logic [XW-1:0] x_next;
  logic [YW-1:0] y_reg;
  logic [YW-1:0] y_next;
  logic          x_end;
  logic          y_end;

  // Position decode; the flags describe the pixel about to be fetched.
  assign x_end         = (x_reg == X_LAST);
  assign y_end         = (y_reg == Y_LAST);
  assign line_first_o  = (x_reg == '0);
  assign frame_first_o = line_first_o && (y_reg == '0);
  assign frame_last_o  = x_end && y_end;

  // Wrap the pixel counter at the line end and the line counter at the
  // frame end.
  assign x_next = x_end ? '0 : x_reg + XW'(1);
  assign y_next = x_end ? (y_end ? '0 : y_reg + YW'(1)) : y_reg;

  // Counters only move on a pixel slot.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      x_reg <= '0;
      y_reg <= '0;
    end else if (pix_en_i) begin
      x_reg <= x_next;
      y_reg <= y_next;
    end
  end

endmodule

// File: design/lpr_rotation.sv
`timescale 1ns/1ps
module lpr_rotation #(
  parameter int PANEL_PIXELS = lpr_pkg::PANEL_PIXELS,
  parameter int PANEL_LINES  = lpr_pkg::PANEL_LINES
) (
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  // Wishbone classic slave.
  input  wire logic                        wb_cyc_i,
  input  wire logic                        wb_stb_i,
  input  wire logic                        wb_we_i,
  input  wire logic [7:0]                  wb_adr_i,
  input  wire logic [31:0]                 wb_dat_i,
  input  wire logic [3:0]                  wb_sel_i,
  output logic      [31:0]                 wb_dat_o,
  output logic                             wb_ack_o,
  // Host display memory access in progress.
  input  wire logic                        cpu_mem_busy_i,
  // Refresh fetch stream towards display memory.
  output logic      [lpr_pkg::ADDR_W-1:0]  fetch_addr_o,
  output logic                             fetch_valid_o,
  output logic                             fetch_frame_o,
  output logic                             fetch_line_o,
  // Clock steering.
  output logic                             input_clock_pin_route_o,
  output logic                             mclk_boost_o,
  output logic                             pixel_clock_en_o
);
  import lpr_pkg::*;

  // ****************************************************************
  // Functions.
  // ****************************************************************

  // True when the bus index selects the given register.
  function automatic logic hit(input logic [IDX_W-1:0] idx,
                               input logic [IDX_W-1:0] reg_idx);
    hit = (idx == reg_idx);
  endfunction

  // True for a single set bit; zero is not a usable stride.
  function automatic logic is_pow2(input logic [REG_W-1:0] v);
    is_pow2 = (v != '0) && ((v & (v - REG_W'(1))) == '0);
  endfunction

  // ****************************************************************
  // Register storage.
  // ****************************************************************
  logic [REG_W-1:0]  start_low_reg;
  logic [REG_W-1:0]  start_mid_reg;
  logic [REG_W-1:0]  start_top_reg;
  logic [REG_W-1:0]  rot_ctrl_reg;
  logic [REG_W-1:0]  stride_reg;
  logic              ack_reg;
  logic [REG_W-1:0]  rdata_reg;

  // ****************************************************************
  // Bus decode.
  // ****************************************************************
  logic [IDX_W-1:0]  bus_idx;
  logic              bus_req;
  logic              wr_take;
  logic              lane0;
  logic [REG_W-1:0]  wr_byte;
  logic              wr_low;
  logic              wr_mid;
  logic              wr_top;
  logic              wr_ctrl;
  logic              wr_stride;

  // The index sits above the byte lane bits of the address.
  assign bus_idx   = wb_adr_i[7:2];
  assign bus_req   = wb_cyc_i && wb_stb_i;
  // Writes land on the edge where the master sees the acknowledge.
  assign wr_take   = bus_req && wb_we_i && ack_reg;
  // Registers are eight bits wide and live on byte lane zero only.
  assign lane0     = wb_sel_i[0];
  assign wr_byte   = wb_dat_i[REG_W-1:0];
  assign wr_low    = wr_take && lane0 && hit(bus_idx, IDX_START_LOW);
  assign wr_mid    = wr_take && lane0 && hit(bus_idx, IDX_START_MID);
  assign wr_top    = wr_take && lane0 && hit(bus_idx, IDX_START_TOP);
  assign wr_ctrl   = wr_take && lane0 && hit(bus_idx, IDX_ROT_CTRL);
  assign wr_stride = wr_take && lane0 && hit(bus_idx, IDX_STRIDE);

  // ****************************************************************
  // Mode decode.
  // ****************************************************************
  logic              portrait_on;
  lpr_scheme_type    scheme;
  logic              alt_on;
  logic              mclk_sel;
  logic              stride_pow2;
  logic [ADDR_W-1:0] start_raw;
  logic [ADDR_W-1:0] stride_ext;
  logic [ADDR_W-1:0] start_eff;

  assign portrait_on = rot_ctrl_reg[CTRL_ENABLE_BIT];
  assign scheme      = rot_ctrl_reg[CTRL_SCHEME_BIT] ? LPR_SCHEME_ALTERNATE
                                                     : LPR_SCHEME_DEFAULT;
  assign alt_on      = portrait_on && (scheme == LPR_SCHEME_ALTERNATE);
  assign mclk_sel    = portrait_on && rot_ctrl_reg[CTRL_MCLK_BIT];
  assign stride_pow2 = is_pow2(stride_reg);

  assign start_raw   = {start_top_reg[0], start_mid_reg, start_low_reg};
  assign stride_ext  = portrait_on ? ADDR_W'(stride_reg) : '0;

  // The effective first fetch address of a frame. In the default
  // scheme the stride is a single bit, so clearing that bit in the
  // offset keeps the line part even; this is why it pans by two lines
  // while the alternate scheme uses the offset as written.
  always_comb begin
    start_eff = start_raw;
    if (!portrait_on) begin
      start_eff = {start_raw[ADDR_W-2:0], 1'b0};
    end else if (!alt_on) begin
      start_eff = start_raw & ~stride_ext;
    end else begin
      start_eff = start_raw;
    end
  end

  // ****************************************************************
  // Clock steering.
  // ****************************************************************
  logic pix_phase_reg;
  logic pix_en;

  assign pix_en = alt_on ? pix_phase_reg : 1'b1;

  // The phase runs free; the halving only matters in the alternate
  // scheme, and the raster simply waits one cycle per pixel there.
  // A free phase costs nothing in the other modes and needs no restart.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pix_phase_reg <= 1'b0;
    end else begin
      pix_phase_reg <= ~pix_phase_reg;
    end
  end

  assign input_clock_pin_route_o = portrait_on;
  assign mclk_boost_o            = mclk_sel && cpu_mem_busy_i;
  assign pixel_clock_en_o        = pix_en;

  // ****************************************************************
  // Raster position.
  // ****************************************************************
  logic line_first;
  logic frame_first;
  logic frame_last;

  lpr_scan #(
    .PIXELS (PANEL_PIXELS),
    .LINES  (PANEL_LINES)
  ) u_scan (
    .clk_i         (clk_i),
    .rst_i         (rst_i),
    .pix_en_i      (pix_en),
    .line_first_o  (line_first),
    .frame_first_o (frame_first),
    .frame_last_o  (frame_last)
  );

  // ****************************************************************
  // Fetch address generation.
  // ****************************************************************
  logic [ADDR_W-1:0] cur_addr_reg;
  logic [ADDR_W-1:0] line_base_reg;
  logic [ADDR_W-1:0] addr_now;
  logic              frame_busy_reg;

  // Portrait frames start at the right edge of the first portrait line
  // and walk down the column; each new panel line moves one byte left.
  // The host side needs no translation: it writes memory linearly with
  // the programmed stride and this walk does the rotation.
  // linear host layout
  always_comb begin
    addr_now = cur_addr_reg + ADDR_W'(1);
    if (frame_first) begin
      addr_now = start_eff;
    end else if (portrait_on && line_first) begin
      addr_now = line_base_reg - ADDR_W'(1);
    end else if (portrait_on) begin
      addr_now = cur_addr_reg + stride_ext;
    end
  end

  // Address state moves on pixel slots only.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cur_addr_reg  <= '0;
      line_base_reg <= '0;
    end else if (pix_en) begin
      cur_addr_reg <= addr_now;
      if (line_first) begin
        line_base_reg <= addr_now;
      end
    end
  end

  // Registered fetch stream; the flags travel with their address.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fetch_addr_o  <= '0;
      fetch_valid_o <= 1'b0;
      fetch_frame_o <= 1'b0;
      fetch_line_o  <= 1'b0;
    end else begin
      fetch_valid_o <= pix_en;
      fetch_frame_o <= pix_en && frame_first;
      fetch_line_o  <= pix_en && line_first;
      if (pix_en) begin
        fetch_addr_o <= addr_now;
      end
    end
  end

  // Status bit showing that a frame is being scanned past its first
  // pixel, so software can time offset changes to the frame gap.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      frame_busy_reg <= 1'b0;
    end else if (pix_en) begin
      frame_busy_reg <= !frame_last;
    end
  end

  // ****************************************************************
  // Register writes.
  // ****************************************************************

  // Offset registers; only bit zero of the top byte exists.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      start_low_reg <= START_RST;
      start_mid_reg <= START_RST;
      start_top_reg <= START_RST;
    end else begin
      if (wr_low) begin
        start_low_reg <= wr_byte;
      end
      if (wr_mid) begin
        start_mid_reg <= wr_byte;
      end
      if (wr_top) begin
        start_top_reg <= wr_byte & TOP_WMASK;
      end
    end
  end

  // Control and stride. A stride that is not a power of two is kept
  // as written; the default scheme then fetches a skewed image, and
  // the status register flags it rather than silently fixing it.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rot_ctrl_reg <= CTRL_RST;
      stride_reg   <= STRIDE_RST;
    end else begin
      if (wr_ctrl) begin
        rot_ctrl_reg <= wr_byte & CTRL_WMASK;
      end
      if (wr_stride) begin
        stride_reg <= wr_byte;
      end
    end
  end

  // ****************************************************************
  // Register reads and acknowledge.
  // ****************************************************************
  // The status word is read only; writes to its index are dropped.
  logic [REG_W-1:0] status_val;
  logic [REG_W-1:0] rd_mux;

  // Status word; frame busy is only a hint, it moves on pixel slots.
  assign status_val = REG_W'({frame_busy_reg, alt_on, portrait_on,
                              mclk_boost_o, stride_pow2});

  // Unmapped indices read as zero and are still acknowledged.
  assign rd_mux =
    hit(bus_idx, IDX_START_LOW) ? start_low_reg :
    hit(bus_idx, IDX_START_MID) ? start_mid_reg :
    hit(bus_idx, IDX_START_TOP) ? start_top_reg :
    hit(bus_idx, IDX_ROT_CTRL)  ? rot_ctrl_reg  :
    hit(bus_idx, IDX_STRIDE)    ? stride_reg    :
    hit(bus_idx, IDX_STATUS)    ? status_val    : '0;

  // One wait cycle, acknowledge for one cycle, then low again.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg   <= 1'b0;
      rdata_reg <= '0;
    end else begin
      ack_reg <= bus_req && !ack_reg;
      if (bus_req && !ack_reg) begin
        rdata_reg <= rd_mux;
      end
    end
  end

  // Acknowledge and read data both come straight from flip-flops.
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = {{(32-REG_W){1'b0}}, rdata_reg};

endmodule

// File: dv/lpr_host_model.sv
`timescale 1ns/1ps
// ****************************************************************
// Host side: a CPU access to display memory lasting len_i cycles.
// ****************************************************************
module lpr_host_model (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       go_i,
  input  wire logic [3:0] len_i,
  output logic            busy_o
);
  logic [3:0] left_reg;
  // A longer len_i models a slow host; the block must simply follow.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      left_reg <= 4'h0;
    end else if (go_i) begin
      left_reg <= len_i;
    end else if (left_reg != 4'h0) begin
      left_reg <= left_reg - 4'h1;
    end
  end
  assign busy_o = left_reg != 4'h0;
endmodule

// File: dv/lpr_rotation_sva.sv
`timescale 1ns/1ps
// ****************************************************************
// Port checker for the portrait rotation block.
// ****************************************************************
module lpr_rotation_sva (
  input wire logic                       clk_i,
  input wire logic                       rst_i,
  input wire logic                       wb_cyc_i,
  input wire logic                       wb_stb_i,
  input wire logic                       wb_we_i,
  input wire logic [7:0]                 wb_adr_i,
  input wire logic [31:0]                wb_dat_i,
  input wire logic [3:0]                 wb_sel_i,
  input wire logic [31:0]                wb_dat_o,
  input wire logic                       wb_ack_o,
  input wire logic                       cpu_mem_busy_i,
  input wire logic [lpr_pkg::ADDR_W-1:0] fetch_addr_o,
  input wire logic                       fetch_valid_o,
  input wire logic                       fetch_frame_o,
  input wire logic                       fetch_line_o,
  input wire logic                       input_clock_pin_route_o,
  input wire logic                       mclk_boost_o,
  input wire logic                       pixel_clock_en_o
);
  import lpr_pkg::*;
  logic [REG_W-1:0]  ctrl_reg;
  logic [REG_W-1:0]  stride_reg;
  logic [ADDR_W-1:0] last_reg;
  logic [ADDR_W-1:0] line_reg;
  logic              clean_reg;
  logic              wr_d_reg;
  // Decode of the bus write that lands at this edge.
  wire [IDX_W-1:0] idx = wb_adr_i[7:2];
  wire wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];
  wire portrait = ctrl_reg[CTRL_ENABLE_BIT];
  wire alt = portrait && ctrl_reg[CTRL_SCHEME_BIT];
  wire mapped = idx inside {IDX_START_LOW, IDX_START_MID, IDX_START_TOP,
                            IDX_ROT_CTRL, IDX_STRIDE, IDX_STATUS};
  // Shadow of the mode, so no internal probes are needed.
  always_ff @(posedge clk_i) begin
    if (rst_i) ctrl_reg <= CTRL_RST;
    else if (wr && idx == IDX_ROT_CTRL)
      ctrl_reg <= wb_dat_i[7:0] & CTRL_WMASK;
    if (rst_i) stride_reg <= STRIDE_RST;
    else if (wr && idx == IDX_STRIDE) stride_reg <= wb_dat_i[7:0];
  end
  // Stepping is judged only in frames begun after the last write had
  // settled, because reprogramming mid-frame gives no guarantee.
  always_ff @(posedge clk_i) begin
    wr_d_reg <= wr;
    if (fetch_valid_o) last_reg <= fetch_addr_o;
    if (fetch_valid_o && fetch_line_o) line_reg <= fetch_addr_o;
    if (rst_i || wr) clean_reg <= 1'b0;
    else if (fetch_valid_o && fetch_frame_o && !wr_d_reg) clean_reg <= 1'b1;
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // A taken request is answered by a single-cycle ack.
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ack_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  chk_ack_timing: assert property (s_take |=> s_ack_pulse)
    else $error("ack not one pulse one cycle after request");
  chk_unmapped_zero: assert property (
    wb_ack_o && !wb_we_i && !mapped |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  chk_boost_cause: assert property (
    mclk_boost_o == (portrait && ctrl_reg[CTRL_MCLK_BIT] && cpu_mem_busy_i))
    else $error("memory clock boost wrong");
  chk_pix_steady: assert property (!alt |-> pixel_clock_en_o)
    else $error("pixel enable gaps outside alternate scheme");
  chk_alt_halving: assert property (
    alt && $past(alt) |-> pixel_clock_en_o != $past(pixel_clock_en_o))
    else $error("alternate pixel enable not halved");
  chk_valid_slot: assert property (
    !$past(rst_i) |-> fetch_valid_o == $past(pixel_clock_en_o))
    else $error("fetch valid not one cycle after slot");
  chk_land_step: assert property (
    clean_reg && !portrait && fetch_valid_o && !fetch_frame_o
    |-> fetch_addr_o == last_reg + 17'h1) else $error("landscape step");
  chk_port_step: assert property (
    clean_reg && portrait && fetch_valid_o && !fetch_line_o
    |-> fetch_addr_o == last_reg + {9'h0, stride_reg})
    else $error("portrait pixel step");
  chk_line_back: assert property (
    clean_reg && portrait && fetch_valid_o && fetch_line_o && !fetch_frame_o
    |-> fetch_addr_o == line_reg - 17'h1) else $error("portrait line step");
endmodule

bind lpr_rotation lpr_rotation_sva u_sva (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
  .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .cpu_mem_busy_i(cpu_mem_busy_i), .fetch_addr_o(fetch_addr_o),
  .fetch_valid_o(fetch_valid_o), .fetch_frame_o(fetch_frame_o),
  .fetch_line_o(fetch_line_o), .mclk_boost_o(mclk_boost_o),
  .input_clock_pin_route_o(input_clock_pin_route_o),
  .pixel_clock_en_o(pixel_clock_en_o)
);

// File: dv/lpr_rotation_tb.sv
`timescale 1ns/1ps
// ****************************************************************
// Self-checking bench for the portrait rotation block.
// ****************************************************************
module lpr_rotation_tb;
  import lpr_pkg::*;
  // A tiny panel keeps every frame to a few dozen cycles.
  localparam int PP = 4;
  localparam int PL = 3;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc   = 1'b0;
  logic        stb   = 1'b0;
  logic        we    = 1'b0;
  logic [7:0]  adr   = 8'h00;
  logic [31:0] dat   = 32'h0;
  logic [3:0]  sel   = 4'h0;
  logic        go    = 1'b0;
  logic [3:0]  len   = 4'h0;
  logic [31:0] rdat;
  logic [31:0] rd_o;
  logic [16:0] fa;
  logic        ack, fv, ff, fl, route, boost, pen, busy;
  int          n_mismatch = 0;
  int          checks = 0;
  lpr_rotation #(.PANEL_PIXELS(PP), .PANEL_LINES(PL)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel),
    .wb_dat_o(rd_o), .wb_ack_o(ack), .cpu_mem_busy_i(busy),
    .fetch_addr_o(fa), .fetch_valid_o(fv), .fetch_frame_o(ff),
    .fetch_line_o(fl), .input_clock_pin_route_o(route),
    .mclk_boost_o(boost), .pixel_clock_en_o(pen)
  );
  lpr_host_model host (
    .clk_i(clk_i), .rst_i(rst_i), .go_i(go), .len_i(len), .busy_o(busy)
  );
  initial begin
    forever #25 clk_i = ~clk_i;
  end
  // Every comparison is counted; a mismatch is printed at once.
  task automatic cmp(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One classic cycle; held until ack is sampled, then released.
  task automatic bus(input logic w, input logic [5:0] i,
                     input logic [7:0] d, input logic s);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= {i, 2'b00};
    dat <= {24'h0, d};
    sel <= {4{s}};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    cmp("ack", 32'h1, {31'h0, ack});
    rdat = rd_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // Reset values, masks, ignored lane writes and an unmapped place.
  task automatic t_regs();
    logic [5:0] ix [6] = '{IDX_START_LOW, IDX_START_MID, IDX_START_TOP,
                           IDX_ROT_CTRL, IDX_STRIDE, 6'h3f};
    logic [7:0] mk [6] = '{8'hff, 8'hff, TOP_WMASK, CTRL_WMASK, 8'hff,
                           8'h00};
    foreach (ix[i]) begin
      bus(1'b0, ix[i], 8'h00, 1'b1);
      cmp("reset_value", {24'h0, START_RST}, rdat);
      bus(1'b1, ix[i], 8'hff, 1'b1);
      bus(1'b1, ix[i], 8'h00, 1'b0);
      bus(1'b0, ix[i], 8'h00, 1'b1);
      cmp("read_back", {24'h0, mk[i]}, rdat);
      bus(1'b1, ix[i], 8'h00, 1'b1);
    end
  endtask
  // Wait for the next fetched pixel, or the next frame start.
  task automatic next_pix(input logic f);
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while ((fv !== 1'b1 || (f && ff !== 1'b1)) && n < 200);
    cmp("fetch_valid", 32'h1, {31'h0, fv});
  endtask
  // Program a mode and compare a whole frame of fetch addresses.
  task automatic t_frame(input logic [7:0] c, input logic [16:0] st,
                         input logic [7:0] sd);
    logic [16:0] eff;
    logic [16:0] ex;
    logic [31:0] est;
    bus(1'b1, IDX_STRIDE, sd, 1'b1);
    bus(1'b1, IDX_START_LOW, st[7:0], 1'b1);
    bus(1'b1, IDX_START_MID, st[15:8], 1'b1);
    bus(1'b1, IDX_START_TOP, {7'h0, st[16]}, 1'b1);
    bus(1'b1, IDX_ROT_CTRL, c, 1'b1);
    bus(1'b0, IDX_STATUS, 8'h00, 1'b1);
    est = {28'h0, c[7] & c[6], c[7], 1'b0, $onehot(sd)};
    cmp("status", est, rdat & 32'hf);
    eff = !c[7] ? {st[15:0], 1'b0} : c[6] ? st : st & ~{9'h0, sd};
    repeat (2) @(posedge clk_i);
    next_pix(1'b1);
    for (int l = 0; l < PL; l++) begin
      for (int p = 0; p < PP; p++) begin
        if (l + p > 0) next_pix(1'b0);
        ex = c[7] ? eff - 17'(l) + 17'(p) * {9'h0, sd}
                  : eff + 17'(l * PP + p);
        cmp("fetch_addr", {15'h0, ex}, {15'h0, fa});
        cmp("fetch_line", {31'h0, p == 0}, {31'h0, fl});
        cmp("fetch_frame", {31'h0, l + p == 0}, {31'h0, ff});
      end
    end
  endtask
  // A host access of three cycles with the given control value.
  task automatic t_boost(input logic [7:0] c);
    bus(1'b1, IDX_ROT_CTRL, c, 1'b1);
    @(posedge clk_i);
    go  <= 1'b1;
    len <= 4'h3;
    @(posedge clk_i);
    go <= 1'b0;
    @(posedge clk_i);
    cmp("mclk_boost", {31'h0, c[7] & c[2]}, {31'h0, boost});
    cmp("clock_route", {31'h0, c[7]}, {31'h0, route});
    repeat (4) @(posedge clk_i);
    cmp("mclk_boost", 32'h0, {31'h0, boost});
  endtask
  task automatic report_and_stop();
    if (n_mismatch == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Main sequence.
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    cmp("reset_out", 32'h1, {9'h0, fa, fv, ff, fl, route, boost, pen});
    t_regs();
    t_frame(8'h00, 17'h00003, 8'h80);
    t_frame(8'h40, 17'h10001, 8'h80);
    t_frame(8'h80, 17'h0007f, 8'h80);
    t_frame(8'h80, 17'h000ff, 8'h80);
    t_frame(8'hc0, 17'h00077, 8'h78);
    t_frame(8'hc0, 17'h00078, 8'h78);
    t_frame(8'hc0, 17'h10000, 8'h78);
    t_boost(8'h84);
    t_boost(8'h80);
    t_boost(8'h04);
    report_and_stop();
  end
  // The whole run needs well under this many cycles.
  initial begin
    repeat (6000) @(posedge clk_i);
    n_mismatch++;
    report_and_stop();
  end
endmodule
